//--- include/core_cfg.svh
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CORE_STATUS   12'h000
`define OFF_CORE_OPTIONS  12'h004
`define OFF_POWER_CONTROL 12'h008
`define OFF_COUNTER_LOW   12'h00C
`define OFF_COUNTER_HOLD  12'h010

// ----------------------------------------------------------------
// core_status fields
// ----------------------------------------------------------------
`define ST_INDIRECT_BANK  7
`define ST_DIRECT_HI      6
`define ST_DIRECT_LO      5
`define ST_WD_EXPIRY      4
`define ST_SLEEP_ENTRY    3
`define ST_RESULT_NULL    2
`define ST_NIBBLE_CARRY   1
`define ST_FULL_CARRY     0

// ----------------------------------------------------------------
// core_options fields
// ----------------------------------------------------------------
`define OPT_PULLUP_DIS    7
`define OPT_IRQ_EDGE      6
`define OPT_T0_SOURCE     5
`define OPT_T0_EDGE       4
`define OPT_PSC_OWNER     3
`define OPT_RATIO_HI      2
`define OPT_RATIO_LO      0

// ----------------------------------------------------------------
// power_control fields
// ----------------------------------------------------------------
`define PC_COLD_START     1
`define PC_LOW_SUPPLY     0

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define RST_CORE_STATUS   8'h18
`define RST_CORE_OPTIONS  8'hFF
`define RST_POWER_CONTROL 2'h3
`define RST_HOLDING       5'h00
`define IRQ_VECTOR        13'h0004
`define SUPPLY_SW_MODE    2'h1
`define INSTR_CLK_DIV     2'h3

`endif

//--- include/core_pkg.sv
package core_pkg;

  typedef enum logic [3:0] {
    PC_HOLD      = 4'h0,
    PC_STEP      = 4'h1,
    PC_CALL      = 4'h2,
    PC_JUMP      = 4'h3,
    PC_IRQ       = 4'h4,
    PC_RETURN    = 4'h5,
    PC_RET_LIT   = 4'h6,
    PC_RET_IRQ   = 4'h7,
    PC_LOW_WRITE = 4'h8,
    PC_LOW_ADD   = 4'h9
  } pc_op_t;

  typedef enum logic [2:0] {
    ALU_ADD   = 3'h0,
    ALU_SUB   = 3'h1,
    ALU_LOGIC = 3'h2,
    ALU_ROTL  = 3'h3,
    ALU_ROTR  = 3'h4
  } alu_op_t;

  typedef enum logic [2:0] {
    SEL_STATUS  = 3'h0,
    SEL_OPTIONS = 3'h1,
    SEL_POWER   = 3'h2,
    SEL_LOW     = 3'h3,
    SEL_HOLD    = 3'h4,
    SEL_NONE    = 3'h7
  } reg_sel_t;

  typedef struct packed {
    pc_op_t      op;
    logic [10:0] target;
    logic [7:0]  data;
  } pc_cmd_t;

  typedef struct packed {
    logic       valid;
    alu_op_t    op;
    logic       dest_status;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_t;

  typedef struct packed {
    logic sleep;
    logic kick;
    logic wd_timeout;
  } power_evt_t;

endpackage : core_pkg

//--- core/core_status_pc_stack.sv
// Operation
// - indirect bank bit picks upper/lower 256 bytes
// - direct bank bits pick one of four banks
// - expiry and sleep flags follow kick/sleep/timeout
// - result-null flag set on zero add, subtract or logic result
// - nibble carry from low four bits
// - full carry from most significant bit
// - subtract adds two's complement, inverted borrow
// - rotates load carry with shifted-out bit
// - pull-up disable turns off all port pull-ups
// - edge select picks external interrupt edge
// - timer0 source: pin or quarter clock
// - timer0 pin polarity select
// - prescaler owner: watchdog or timer0
// - ratio field sets the prescaler owner's division rate only
// - reset causes clear flags, software resets
// - low-supply bit enables monitor in mode 01
// - 13-bit counter, low byte visible, reset clears
// - low byte write loads upper bits from holding
// - call/jump page bits from holding 4:3
// - hidden 8x13 return stack, push/pop
// - stack wraps circularly, no overflow flag
// - return restores full counter, holding untouched
// - flag writes ignored when alu targets status
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "core_cfg.svh"

module core_status_pc_stack (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire core_pkg::pc_cmd_t   pc_cmd,
  input  wire core_pkg::alu_req_t  alu_req,
  input  wire core_pkg::power_evt_t power_evt,
  input  wire logic                power_on_cause,
  input  wire logic                brown_out_cause,
  input  wire logic [1:0]          supply_monitor_mode,
  input  wire logic [7:0]          per_pin_pullup_reg,
  input  wire logic                ext_irq_pin,
  input  wire logic                timer0_ext_clock_pin,
  input  wire logic                watchdog_osc_tick,
  output logic [12:0]              program_counter,
  output logic [7:0]               alu_result,
  output logic [7:0]               core_status,
  output logic                     indirect_bank_bit,
  output logic [1:0]               direct_bank_bits,
  output logic [7:0]               port_b_pullup_en,
  output logic                     ext_irq_event,
  output logic                     timer0_inc,
  output logic                     watchdog_inc,
  output logic                     supply_monitor_en
);
  import core_pkg::*;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [11:0] addr);
    case (addr)
      `OFF_CORE_STATUS:   decode = SEL_STATUS;
      `OFF_CORE_OPTIONS:  decode = SEL_OPTIONS;
      `OFF_POWER_CONTROL: decode = SEL_POWER;
      `OFF_COUNTER_LOW:   decode = SEL_LOW;
      `OFF_COUNTER_HOLD:  decode = SEL_HOLD;
      default:            decode = SEL_NONE;
    endcase
  endfunction : decode

  logic [7:0]  status_reg;
  logic [7:0]  options_reg;
  logic [1:0]  power_reg;
  logic [4:0]  holding_reg;
  logic [12:0] pc_reg;
  logic [12:0] stack_mem [0:7];
  logic [2:0]  sp_reg;
  logic        first_reg;
  reg_sel_t    sel;
  logic        wr_lane0;
  logic        wr_status;
  logic        wr_options;
  logic        wr_power;
  logic        wr_low;
  logic        wr_hold;

  assign sel        = decode(paddr);
  // only byte lane 0 carries the 8-bit registers
  assign wr_lane0   = psel & penable & pwrite & pstrb[0];
  assign wr_status  = wr_lane0 & (sel == SEL_STATUS);
  assign wr_options = wr_lane0 & (sel == SEL_OPTIONS);
  assign wr_power   = wr_lane0 & (sel == SEL_POWER);
  assign wr_low     = wr_lane0 & (sel == SEL_LOW);
  assign wr_hold    = wr_lane0 & (sel == SEL_HOLD);
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & (sel == SEL_NONE);

  // read data latched in the setup phase, so it is a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (sel)
        SEL_STATUS:  prdata <= {24'h00_0000, status_reg};
        SEL_OPTIONS: prdata <= {24'h00_0000, options_reg};
        SEL_POWER:   prdata <= {30'h0000_0000, power_reg};
        SEL_LOW:     prdata <= {24'h00_0000, pc_reg[7:0]};
        SEL_HOLD:    prdata <= {27'h000_0000, holding_reg};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] res;
  logic [7:0] b_eff;
  logic       carry_new;

  always_comb begin
    b_eff     = (alu_req.op == ALU_SUB) ? ~alu_req.b : alu_req.b;
    sum9      = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, alu_req.op == ALU_SUB};
    nib5      = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]}
              + {4'h0, alu_req.op == ALU_SUB};
    res       = sum9[7:0];
    carry_new = sum9[8];
    case (alu_req.op)
      ALU_LOGIC: begin
        res       = alu_req.a;
        carry_new = status_reg[`ST_FULL_CARRY];
      end
      ALU_ROTL: begin
        res       = {alu_req.a[6:0], status_reg[`ST_FULL_CARRY]};
        carry_new = alu_req.a[7];
      end
      ALU_ROTR: begin
        res       = {status_reg[`ST_FULL_CARRY], alu_req.a[7:1]};
        carry_new = alu_req.a[0];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_result <= 8'h00;
    end else if (alu_req.valid) begin
      alu_result <= res;
    end
  end

  // ----------------------------------------------------------------
  // core_status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `RST_CORE_STATUS;
    end else begin
      if (wr_status) begin
        status_reg[7:5] <= pwdata[7:5];
        status_reg[2:0] <= pwdata[2:0];
      end
      if (alu_req.valid && alu_req.dest_status) begin
        status_reg[7:5] <= res[7:5];
      end
      if (alu_req.valid) begin
        case (alu_req.op)
          ALU_ADD, ALU_SUB: begin
            status_reg[`ST_RESULT_NULL]  <= (res == 8'h00);
            status_reg[`ST_NIBBLE_CARRY] <= nib5[4];
            status_reg[`ST_FULL_CARRY]   <= carry_new;
          end
          ALU_LOGIC: status_reg[`ST_RESULT_NULL] <= (res == 8'h00);
          ALU_ROTL, ALU_ROTR: status_reg[`ST_FULL_CARRY] <= carry_new;
          default: begin
          end
        endcase
      end
      // expiry and sleep flags are never software writable
      if (power_evt.kick) begin
        status_reg[`ST_WD_EXPIRY]   <= 1'b1;
        status_reg[`ST_SLEEP_ENTRY] <= 1'b1;
      end else if (power_evt.sleep) begin
        status_reg[`ST_WD_EXPIRY]   <= 1'b1;
        status_reg[`ST_SLEEP_ENTRY] <= 1'b0;
      end
      if (power_evt.wd_timeout) begin
        status_reg[`ST_WD_EXPIRY] <= 1'b0;
      end
    end
  end

  assign core_status       = status_reg;
  assign indirect_bank_bit = status_reg[`ST_INDIRECT_BANK];
  assign direct_bank_bits  = status_reg[`ST_DIRECT_HI:`ST_DIRECT_LO];

  // ----------------------------------------------------------------
  // core_options and power_control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options_reg <= `RST_CORE_OPTIONS;
    end else if (wr_options) begin
      options_reg <= pwdata[7:0];
    end
  end

  // cause straps are caught in the first cycle after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_reg <= `RST_POWER_CONTROL;
    end else begin
      if (wr_power) begin
        power_reg <= pwdata[1:0];
      end
      if (first_reg && power_on_cause) begin
        power_reg <= 2'h0;
      end else if (first_reg && brown_out_cause) begin
        power_reg[`PC_LOW_SUPPLY] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_monitor_en <= 1'b0;
      port_b_pullup_en  <= 8'h00;
    end else begin
      supply_monitor_en <= (supply_monitor_mode == `SUPPLY_SW_MODE)
                         & power_reg[`PC_LOW_SUPPLY];
      port_b_pullup_en  <= options_reg[`OPT_PULLUP_DIS] ? 8'h00 : per_pin_pullup_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin edges, instruction clock, shared prescaler
  // ----------------------------------------------------------------
  logic       irq_prev_reg;
  logic       t0_prev_reg;
  logic [1:0] phase_reg;
  logic [7:0] psc_reg;
  logic [7:0] psc_next;
  logic [7:0] psc_mask;
  logic [2:0] ratio;
  logic       t0_pin_evt;
  logic       t0_evt;
  logic       psc_evt;
  logic       psc_hit;

  assign ratio      = options_reg[`OPT_RATIO_HI:`OPT_RATIO_LO];
  // no edge in the first cycle out of reset: the pin may idle high
  assign t0_pin_evt = ~first_reg
                    & (options_reg[`OPT_T0_EDGE] ? (t0_prev_reg & ~timer0_ext_clock_pin)
                    : (~t0_prev_reg & timer0_ext_clock_pin));
  assign t0_evt     = options_reg[`OPT_T0_SOURCE] ? t0_pin_evt
                    : (phase_reg == `INSTR_CLK_DIV);
  assign psc_evt    = options_reg[`OPT_PSC_OWNER] ? watchdog_osc_tick : t0_evt;
  // timer0 divides by 2^(n+1), the watchdog by 2^n
  assign psc_mask   = options_reg[`OPT_PSC_OWNER]
                    ? 8'((9'h001 << ratio) - 9'h001)
                    : 8'((9'h002 << ratio) - 9'h001);
  assign psc_next   = psc_reg + 8'h01;
  assign psc_hit    = psc_evt & ((psc_next & psc_mask) == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_reg <= 1'b0;
      t0_prev_reg  <= 1'b0;
      phase_reg    <= 2'h0;
    end else begin
      irq_prev_reg <= ext_irq_pin;
      t0_prev_reg  <= timer0_ext_clock_pin;
      phase_reg    <= phase_reg + 2'h1;
    end
  end

  // restarting on an options write avoids a short first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_reg <= 8'h00;
    end else if (wr_options) begin
      psc_reg <= 8'h00;
    end else if (psc_evt) begin
      psc_reg <= psc_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_event <= 1'b0;
      timer0_inc    <= 1'b0;
      watchdog_inc  <= 1'b0;
    end else begin
      ext_irq_event <= ~first_reg
                     & (options_reg[`OPT_IRQ_EDGE] ? (ext_irq_pin & ~irq_prev_reg)
                     : (~ext_irq_pin & irq_prev_reg));
      timer0_inc    <= options_reg[`OPT_PSC_OWNER] ? t0_evt : psc_hit;
      watchdog_inc  <= options_reg[`OPT_PSC_OWNER] ? psc_hit : watchdog_osc_tick;
    end
  end

  // ----------------------------------------------------------------
  // program counter, holding register, return stack
  // ----------------------------------------------------------------
  logic [2:0] sp_prev;
  assign sp_prev = sp_reg - 3'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holding_reg <= `RST_HOLDING;
    end else if (wr_hold) begin
      holding_reg <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= 13'h0000;
    end else if (wr_low) begin
      pc_reg <= {holding_reg, pwdata[7:0]};
    end else begin
      case (pc_cmd.op)
        PC_STEP:  pc_reg <= pc_reg + 13'h0001;
        PC_CALL, PC_JUMP: pc_reg <= {holding_reg[4:3], pc_cmd.target};
        PC_IRQ:   pc_reg <= `IRQ_VECTOR;
        PC_RETURN, PC_RET_LIT, PC_RET_IRQ: pc_reg <= stack_mem[sp_prev];
        PC_LOW_WRITE: pc_reg <= {holding_reg, pc_cmd.data};
        PC_LOW_ADD:   pc_reg <= {holding_reg, pc_reg[7:0] + pc_cmd.data};
        default: begin
        end
      endcase
    end
  end

  // pointer wraps silently: ninth push lands on the first slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= 3'h0;
    end else if (!wr_low) begin
      case (pc_cmd.op)
        PC_CALL, PC_IRQ: sp_reg <= sp_reg + 3'h1;
        PC_RETURN, PC_RET_LIT, PC_RET_IRQ: sp_reg <= sp_prev;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (presetn && !wr_low) begin
      if (pc_cmd.op == PC_CALL) begin
        stack_mem[sp_reg] <= pc_reg + 13'h0001;
      end else if (pc_cmd.op == PC_IRQ) begin
        stack_mem[sp_reg] <= pc_reg;
      end
    end
  end

  assign program_counter = pc_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic arith;
  assign arith = alu_req.valid & (alu_req.op == ALU_ADD || alu_req.op == ALU_SUB);

  chk_low_write_load: assert property (wr_low |=>
    pc_reg == {$past(holding_reg), $past(pwdata[7:0])})
    else $error("low byte write did not load holding bits");
  chk_jump_page: assert property ((pc_cmd.op == PC_JUMP) && !wr_low |=>
    pc_reg == {$past(holding_reg[4:3]), $past(pc_cmd.target)})
    else $error("jump target page wrong");
  chk_call_return: assert property (
    (pc_cmd.op == PC_CALL && !wr_low) ##1 (pc_cmd.op == PC_RETURN && !wr_low)
    |=> pc_reg == $past(pc_reg, 2) + 13'h0001)
    else $error("return did not restore called address");
  chk_holding_kept: assert property ((pc_cmd.op inside {PC_CALL, PC_RETURN,
    PC_RET_LIT, PC_RET_IRQ, PC_IRQ}) && !wr_hold |=> $stable(holding_reg))
    else $error("holding register moved on stack action");
  chk_add_carry: assert property (arith && alu_req.op == ALU_ADD |=>
    status_reg[0] == (($past(alu_req.a) + $past(alu_req.b)) > 9'h0FF))
    else $error("add carry wrong");
  chk_sub_borrow: assert property (arith && alu_req.op == ALU_SUB |=>
    status_reg[0] == ($past(alu_req.a) >= $past(alu_req.b)))
    else $error("subtract carry is not inverted borrow");
  chk_nibble_carry: assert property (arith && alu_req.op == ALU_ADD |=>
    status_reg[1] == (($past(alu_req.a[3:0]) + $past(alu_req.b[3:0])) > 5'h0F))
    else $error("nibble carry wrong");
  chk_zero_flag: assert property (arith |=> status_reg[2] == (alu_result == 8'h00))
    else $error("result-null flag disagrees with result");
  chk_rotate_carry: assert property (alu_req.valid && alu_req.op == ALU_ROTL |=>
    status_reg[0] == $past(alu_req.a[7]))
    else $error("rotate left carry wrong");
  chk_sleep_flags: assert property (power_evt.sleep && !power_evt.kick
    && !power_evt.wd_timeout |=> !status_reg[3] && status_reg[4])
    else $error("sleep flags wrong");
  chk_pullup_off: assert property (options_reg[7] |=> port_b_pullup_en == 8'h00)
    else $error("pull-ups not disabled");
  chk_stack_wrap: assert property ((pc_cmd.op == PC_CALL) && !wr_low && sp_reg == 3'h7
    |=> sp_reg == 3'h0)
    else $error("stack pointer did not wrap");

  cov_call_return: cover property ((pc_cmd.op == PC_CALL) ##1 (pc_cmd.op == PC_RETURN));
  cov_sub_borrow:  cover property (arith && alu_req.op == ALU_SUB ##1 !status_reg[0]);
  cov_low_write:   cover property (wr_low);
  cov_psc_tick:    cover property (timer0_inc && !options_reg[3]);

endmodule : core_status_pc_stack

//--- bench/core_sequencer.sv
`timescale 1ns/1ps

module core_sequencer (
  input  wire logic            pclk,
  output core_pkg::pc_cmd_t    pc_cmd,
  output core_pkg::alu_req_t   alu_req,
  output core_pkg::power_evt_t power_evt
);
  import core_pkg::*;
  // ----------------------------------------------------------------
  // one-cycle command issue
  // ----------------------------------------------------------------
  // pc_cmd is a level: held longer it would repeat, so it drops to hold
  initial begin
    pc_cmd = {PC_HOLD, 19'h0_0000};
    alu_req = 21'h00_0000;
    power_evt = 3'h0;
  end

  task automatic pc_do(input pc_op_t op, input logic [10:0] t, input logic [7:0] d);
    @(posedge pclk);
    pc_cmd <= {op, t, d};
    @(posedge pclk);
    pc_cmd <= {PC_HOLD, 19'h0_0000};
  endtask : pc_do

  task automatic pc_pair(input pc_op_t op, input logic [10:0] t, input pc_op_t op2);
    @(posedge pclk);
    pc_cmd <= {op, t, 8'h00};
    @(posedge pclk);
    pc_cmd <= {op2, 11'h000, 8'h00};
    @(posedge pclk);
    pc_cmd <= {PC_HOLD, 19'h0_0000};
  endtask : pc_pair

  task automatic alu_do(input alu_op_t op, input logic dst, input logic [7:0] a, b);
    @(posedge pclk);
    alu_req <= {1'b1, op, dst, a, b};
    @(posedge pclk);
    alu_req <= 21'h00_0000;
  endtask : alu_do

  task automatic evt_do(input power_evt_t e);
    @(posedge pclk);
    power_evt <= e;
    @(posedge pclk);
    power_evt <= 3'h0;
  endtask : evt_do
endmodule : core_sequencer

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "core_cfg.svh"

module testbench;
  import core_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        poc, boc, irq_pin, t0_pin, wd_tick, ibank, irq_ev, t0_inc, wd_inc, sm_en;
  logic [1:0]  smm, dbank;
  logic [7:0]  pullreg, alu_result, core_status, pullup_en;
  logic [12:0] program_counter, prev;
  logic [12:0] push [9];
  pc_cmd_t     pc_cmd;
  alu_req_t    alu_req;
  power_evt_t  power_evt;
  pc_op_t      kinds [3] = '{PC_RETURN, PC_RET_LIT, PC_RET_IRQ};
  int          failures = 0, tests_run = 0, n_irq = 0, n_t0 = 0, n_wd = 0;
  int          c_irq, c_t0, c_wd, d;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // pulse counters; checks compare against snapshots, not the absolute value
  always @(posedge pclk) begin
    n_irq <= n_irq + int'(irq_ev);
    n_t0 <= n_t0 + int'(t0_inc);
    n_wd <= n_wd + int'(wd_inc);
  end

  core_status_pc_stack core_status_pc_stack_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_cmd(pc_cmd), .alu_req(alu_req), .power_evt(power_evt),
    .power_on_cause(poc), .brown_out_cause(boc), .supply_monitor_mode(smm),
    .per_pin_pullup_reg(pullreg), .ext_irq_pin(irq_pin), .timer0_ext_clock_pin(t0_pin),
    .watchdog_osc_tick(wd_tick), .program_counter(program_counter),
    .alu_result(alu_result), .core_status(core_status), .indirect_bank_bit(ibank),
    .direct_bank_bits(dbank), .port_b_pullup_en(pullup_en), .ext_irq_event(irq_ev),
    .timer0_inc(t0_inc), .watchdog_inc(wd_inc), .supply_monitor_en(sm_en));

  core_sequencer core_sequencer_inst (
    .pclk(pclk), .pc_cmd(pc_cmd), .alu_req(alu_req), .power_evt(power_evt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) begin
      failures++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr

  task automatic alu(input alu_op_t op, input logic [7:0] a, b, r, input logic [2:0] f);
    core_sequencer_inst.alu_do(op, 1'b0, a, b);
    #1;
    chk(alu_result, r);
    chk(core_status[2:0], f);
  endtask : alu

  task automatic pc_go(input pc_op_t op, input logic [10:0] t);
    core_sequencer_inst.pc_do(op, t, 8'hD0);
    #1;
  endtask : pc_go

  task automatic evt(input power_evt_t v, input logic [1:0] exp);
    core_sequencer_inst.evt_do(v);
    #1;
    chk(core_status[4:3], exp);
  endtask : evt

  task automatic pins(input logic v);
    irq_pin <= v;
    t0_pin <= v;
    repeat (4) @(posedge pclk);
  endtask : pins

  task automatic snap;
    repeat (2) @(posedge pclk);
    c_irq = n_irq;
    c_t0 = n_t0;
    c_wd = n_wd;
  endtask : snap

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, boc, irq_pin, t0_pin, wd_tick} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    poc = 1'b1;
    smm = 2'h1;
    pullreg = 8'hA5;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_CORE_STATUS, 32'h0000_0018);
    chk(program_counter, 13'h0000);
    rd(`OFF_CORE_OPTIONS, 32'h0000_00FF);
    rd(`OFF_POWER_CONTROL, 32'h0000_0000);
    wr(`OFF_POWER_CONTROL, 32'h0000_0003);
    rd(`OFF_POWER_CONTROL, 32'h0000_0003);
    chk(sm_en, 1'b1);
    smm <= 2'h0;
    repeat (2) @(posedge pclk);
    chk(sm_en, 1'b0);
    smm <= 2'h1;
    wr(`OFF_POWER_CONTROL, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(sm_en, 1'b0);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    evt(3'h4, 2'h2);
    wr(`OFF_CORE_STATUS, 32'h0000_00A8);
    #1;
    chk(core_status, 8'hB0);
    chk({ibank, dbank}, 3'h5);
    evt(3'h1, 2'h0);
    evt(3'h2, 2'h3);
    wr(`OFF_CORE_STATUS, 32'h0000_0040);
    #1;
    chk({ibank, dbank}, 3'h2);
    alu(ALU_ADD, 8'h0F, 8'h01, 8'h10, 3'h2);
    alu(ALU_ADD, 8'hFF, 8'h01, 8'h00, 3'h7);
    alu(ALU_SUB, 8'h05, 8'h03, 8'h02, 3'h3);
    alu(ALU_SUB, 8'h03, 8'h05, 8'hFE, 3'h0);
    alu(ALU_ROTL, 8'h80, 8'h00, 8'h00, 3'h1);
    alu(ALU_ROTR, 8'h01, 8'h00, 8'h80, 3'h1);
    alu(ALU_LOGIC, 8'h00, 8'h00, 8'h00, 3'h5);
    core_sequencer_inst.alu_do(ALU_LOGIC, 1'b1, 8'hE0, 8'h00);
    #1;
    chk(core_status, 8'hF9);
    wr(`OFF_CORE_OPTIONS, 32'h0000_0000);
    snap();
    repeat (80) @(posedge pclk);
    chk(pullup_en, 8'hA5);
    d = n_t0 - c_t0;
    chk(d >= 9 && d <= 11, 1'b1);
    wr(`OFF_CORE_OPTIONS, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    chk(pullup_en, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_CORE_OPTIONS, k ? 32'h0000_0078 : 32'h0000_0028);
      snap();
      pins(1'b1);
      chk(32'(n_irq - c_irq), 32'(k));
      chk(32'(n_t0 - c_t0), 32'(1 - k));
      pins(1'b0);
      chk(32'(n_irq - c_irq), 32'h0000_0001);
      chk(32'(n_t0 - c_t0), 32'h0000_0001);
    end
    wr(`OFF_CORE_OPTIONS, 32'h0000_000A);
    snap();
    repeat (8) begin
      wd_tick <= 1'b1;
      @(posedge pclk);
      wd_tick <= 1'b0;
      @(posedge pclk);
    end
    @(posedge pclk);
    chk(32'(n_wd - c_wd), 32'h0000_0002);
    wr(`OFF_COUNTER_HOLD, 32'h0000_001F);
    wr(`OFF_COUNTER_LOW, 32'h0000_0034);
    #1;
    chk(program_counter, 13'h1F34);
    rd(`OFF_COUNTER_LOW, 32'h0000_0034);
    pc_go(PC_LOW_ADD, 11'h000);
    chk(program_counter, 13'h1F04);
    pc_go(PC_JUMP, 11'h123);
    chk(program_counter, 13'h1923);
    prev = 13'h1923;
    for (int i = 0; i < 9; i++) begin
      push[i] = prev + 13'h0001;
      prev = {2'b11, 11'(i * 16)};
      pc_go(PC_CALL, prev[10:0]);
      chk(program_counter, prev);
    end
    // nine pops after nine pushes: the last one finds the ninth push again
    for (int j = 0; j < 9; j++) begin
      pc_go(kinds[j % 3], 11'h000);
      chk(program_counter, push[j == 8 ? 8 : 8 - j]);
    end
    rd(`OFF_COUNTER_HOLD, 32'h0000_001F);
    pc_go(PC_IRQ, 11'h000);
    chk(program_counter, 13'h0004);
    pc_go(PC_RET_IRQ, 11'h000);
    chk(program_counter, push[8]);
    core_sequencer_inst.pc_pair(PC_CALL, 11'h055, PC_RETURN);
    #1;
    chk(program_counter, push[8] + 13'h0001);
    @(posedge pclk);
    presetn <= 1'b0;
    poc <= 1'b0;
    boc <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_POWER_CONTROL, 32'h0000_0002);
    chk(program_counter, 13'h0000);
    stop_test();
  end
endmodule : testbench
